// >>> logic/psc_top.sv
// power-saving control: apb registers steering oscillators, clocks and standbys
// Notes on behaviour
// - each voltage detect circuit is disabled when its enable bit is 0
// - port direction and output held unchanged in wait and stop
// - low-speed oscillator stops when off bit 1 and crystal selected
// - high-speed oscillator stops when its enable bit is 0
// - divided peripheral clocks stop in wait when stop-in-wait bit 1
// - each general timer count source cut off when its cutoff bit 1
// - third timer enters standby when its standby bit is 1
// - sync serial unit and i2c enter standby on shared bit 1
// - adc stops and analog current cut when standby bit is 0
// - flash stopped, accesses blocked, while flash-stop bit is 1 in low-speed mode
// - flash power removed in wait or stop unless rewrite mode enabled
// - low-current read bit 1 in low-speed mode selects reduced-current reads
// - power-reduce bit lowers internal power in wait from low-speed mode
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "psc_cfg.svh"
module psc_top
  import psc_pkg::*;
#(
  parameter int PORT_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic detect0_on,
  output logic detect1_on,
  output logic detect2_on,
  output logic low_osc_run,
  output logic high_osc_run,
  output logic periph_clk_en,
  output logic timer_a_clk_en,
  output logic timer_b_clk_en,
  output logic timer_c_standby,
  output logic serial_sync_standby,
  output logic adc_active,
  output logic flash_power_on,
  output logic flash_access_block,
  output logic flash_low_current_read,
  output logic internal_power_reduced,
  output logic [PORT_W-1:0] port_dir,
  output logic [PORT_W-1:0] port_out
);
  // port registers are read back through one 32-bit word
  if (PORT_W < 1 || PORT_W > 32) begin : g_bad_port_w
    $error("psc_top: PORT_W out of range");
  end

  // ==========================================================
  // apb slave
  // ==========================================================
  logic [31:0] vdet_ff, clk_ff, mod_ff, flash_ff, mode_ff;
  logic [31:0] nxt_vdet, nxt_clk, nxt_mod, nxt_flash, nxt_mode;
  logic pready_ff, pslverr_ff;
  logic [31:0] prdata_ff;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  // writes land only at the access edge, and only while enabled
  wire setup = psel & ~penable;
  wire acc_done = psel & penable & pready_ff;
  wire wr = acc_done & pwrite & clk_en;
  wire sel_vdet = hit(paddr, `PSC_OFF_VDET);
  wire sel_clk = hit(paddr, `PSC_OFF_CLK);
  wire sel_mod = hit(paddr, `PSC_OFF_MOD);
  wire sel_flash = hit(paddr, `PSC_OFF_FLASH);
  wire sel_mode = hit(paddr, `PSC_OFF_MODE);
  wire sel_stat = hit(paddr, `PSC_OFF_STAT);
  wire sel_pdir = hit(paddr, `PSC_OFF_PORTDIR);
  wire sel_pout = hit(paddr, `PSC_OFF_PORTOUT);
  wire mapped = sel_vdet | sel_clk | sel_mod | sel_flash | sel_mode | sel_stat
              | sel_pdir | sel_pout;

  // ==========================================================
  // mode decode
  // ==========================================================
  psc_mode_e mode_now;
  assign mode_now = psc_mode_e'(mode_ff[1:0]);
  wire in_wait = mode_now == PSC_WAIT;
  wire in_stop = mode_now == PSC_STOP;
  wire sleeping = in_wait | in_stop;
  wire [1:0] mode_wdata = pwdata[1:0];
  wire mode_legal = mode_wdata != `PSC_MODE_RSVD;

  // ==========================================================
  // register next values
  // ==========================================================
  logic [PORT_W-1:0] dir_q, out_q;
  assign nxt_vdet = (wr & sel_vdet) ? (pwdata & `PSC_MSK_VDET) : vdet_ff;
  assign nxt_clk = (wr & sel_clk) ? (pwdata & `PSC_MSK_CLK) : clk_ff;
  assign nxt_mod = (wr & sel_mod) ? (pwdata & `PSC_MSK_MOD) : mod_ff;
  assign nxt_flash = (wr & sel_flash) ? (pwdata & `PSC_MSK_FLASH) : flash_ff;
  // unencoded mode value is ignored, a reserved state
  assign nxt_mode = (wr & sel_mode & mode_legal) ? (pwdata & `PSC_MSK_MODE) : mode_ff;

  wire [31:0] stat_word = {25'h000_0000, flash_access_block, flash_power_on,
                           adc_active, internal_power_reduced, low_osc_run,
                           high_osc_run, periph_clk_en};
  wire [31:0] pdir_word = 32'(dir_q);
  wire [31:0] pout_word = 32'(out_q);
  // unmapped reads return zero along with the error flag
  wire [31:0] rd_mux = sel_vdet ? vdet_ff :
                       sel_clk ? clk_ff :
                       sel_mod ? mod_ff :
                       sel_flash ? flash_ff :
                       sel_mode ? mode_ff :
                       sel_stat ? stat_word :
                       sel_pdir ? pdir_word :
                       sel_pout ? pout_word : `PSC_RST_ZERO;

  // ==========================================================
  // register flops, one short block each
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vdet_ff <= `PSC_RST_VDET;
    end else if (clk_en) begin
      vdet_ff <= nxt_vdet;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_ff <= `PSC_RST_CLK;
    end else if (clk_en) begin
      clk_ff <= nxt_clk;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mod_ff <= `PSC_RST_MOD;
    end else if (clk_en) begin
      mod_ff <= nxt_mod;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_ff <= `PSC_RST_FLASH;
    end else if (clk_en) begin
      flash_ff <= nxt_flash;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= `PSC_RST_ZERO;
    end else if (clk_en) begin
      mode_ff <= nxt_mode;
    end
  end

  // no wait state: ready in the first access cycle, answer registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= `PSC_RST_ZERO;
    end else if (clk_en) begin
      pready_ff <= setup;
      pslverr_ff <= setup & ~mapped;
      if (setup) prdata_ff <= pwrite ? `PSC_RST_ZERO : rd_mux;
    end
  end
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign prdata = prdata_ff;

  // ==========================================================
  // ports kept through sleep
  // ==========================================================
  // port hold
  psc_port_hold #(.WIDTH(PORT_W)) u_hold (
    .pclk(pclk),
    .presetn(presetn),
    .ce(clk_en),
    .wr_dir(wr & sel_pdir),
    .wr_out(wr & sel_pout),
    .lowpower(sleeping),
    .wdata(pwdata[PORT_W-1:0]),
    .dir_ff(dir_q),
    .out_ff(out_q)
  );
  assign port_dir = dir_q;
  assign port_out = out_q;

  // ==========================================================
  // control outputs, all registered
  // ==========================================================
  // detector enables
  wire n_det0 = nxt_vdet[`PSC_B_DET0];
  wire n_det1 = nxt_vdet[`PSC_B_DET1];
  wire n_det2 = nxt_vdet[`PSC_B_DET2];
  // low osc stops only with crystal selected
  wire n_low = ~(nxt_clk[`PSC_B_LOWOFF] & ~nxt_clk[`PSC_B_SYSSEL]);
  wire n_hi = nxt_clk[`PSC_B_HIEN];
  // peripheral clocks gated in wait with stop-in-wait bit 1, and always in stop
  wire n_wait = psc_mode_e'(nxt_mode[1:0]) == PSC_WAIT;
  wire n_stop = psc_mode_e'(nxt_mode[1:0]) == PSC_STOP;
  wire n_low_mode = nxt_mode[`PSC_B_LOWMODE];
  wire n_pclk = ~(nxt_clk[`PSC_B_PCSW] & n_wait) & ~n_stop;
  wire n_ta = ~nxt_mod[`PSC_B_CUTA];
  wire n_tb = ~nxt_mod[`PSC_B_CUTB];
  wire n_tc = nxt_mod[`PSC_B_STBC];
  wire n_ss = nxt_mod[`PSC_B_STBS];
  // adc runs only with standby bit 1
  wire n_adc = nxt_mod[`PSC_B_ADC];
  // flash stop blocks access, meaningful in low-speed mode
  // stop bit is stored outside low-speed mode but has no effect there
  wire n_fstop = nxt_flash[`PSC_B_FSTOP] & n_low_mode;
  // auto power-off in sleep without rewrite mode
  // rewrite mode keeps flash powered so an erase is never cut short
  wire n_sleep_off = (n_wait | n_stop) & ~nxt_flash[`PSC_B_REWR];
  wire n_fpwr = ~n_fstop & ~n_sleep_off;
  wire n_fblock = n_fstop | n_sleep_off;
  // reduced-current reads only in low-speed mode, awake
  // forced off in sleep, even if software skipped the clear
  wire n_lcr = nxt_flash[`PSC_B_LCRD] & n_low_mode & ~n_wait & ~n_stop;
  // power reduction in wait from low-speed mode
  wire n_ipr = nxt_vdet[`PSC_B_IPR] & n_wait & n_low_mode;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      detect0_on <= 1'b1;
      detect1_on <= 1'b1;
      detect2_on <= 1'b1;
    end else if (clk_en) begin
      detect0_on <= n_det0;
      detect1_on <= n_det1;
      detect2_on <= n_det2;
    end
  end

  // oscillator and clock flops
  // fed from next values, so outputs move on the write edge itself
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_osc_run <= 1'b1;
      high_osc_run <= 1'b1;
      periph_clk_en <= 1'b1;
    end else if (clk_en) begin
      low_osc_run <= n_low;
      high_osc_run <= n_hi;
      periph_clk_en <= n_pclk;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_a_clk_en <= 1'b1;
      timer_b_clk_en <= 1'b1;
      timer_c_standby <= 1'b0;
      serial_sync_standby <= 1'b0;
      adc_active <= 1'b0;
    end else if (clk_en) begin
      timer_a_clk_en <= n_ta;
      timer_b_clk_en <= n_tb;
      timer_c_standby <= n_tc;
      serial_sync_standby <= n_ss;
      adc_active <= n_adc;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_power_on <= 1'b1;
      flash_access_block <= 1'b0;
      flash_low_current_read <= 1'b0;
    end else if (clk_en) begin
      flash_power_on <= n_fpwr;
      flash_access_block <= n_fblock;
      flash_low_current_read <= n_lcr;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      internal_power_reduced <= 1'b0;
    end else if (clk_en) begin
      internal_power_reduced <= n_ipr;
    end
  end
endmodule

// >>> shared/psc_cfg.svh
// register map, field positions and reset values of the power-saving control block
`ifndef PSC_CFG_SVH
`define PSC_CFG_SVH
`define PSC_OFF_VDET 12'h000
`define PSC_OFF_CLK 12'h004
`define PSC_OFF_MOD 12'h008
`define PSC_OFF_FLASH 12'h00C
`define PSC_OFF_MODE 12'h010
`define PSC_OFF_STAT 12'h014
`define PSC_OFF_PORTDIR 12'h018
`define PSC_OFF_PORTOUT 12'h01C
// voltage_detect_ctrl
`define PSC_B_IPR 0
`define PSC_B_DET0 5
`define PSC_B_DET1 6
`define PSC_B_DET2 7
`define PSC_RST_VDET 32'h0000_00E0
// clock control: low_osc_off, sys_clock_select, high_osc_enable, periph stop
`define PSC_B_LOWOFF 0
`define PSC_B_SYSSEL 1
`define PSC_B_HIEN 2
`define PSC_B_PCSW 3
`define PSC_RST_CLK 32'h0000_0006
// module control: cutoff a/b, standby c, sync serial, adc
`define PSC_B_CUTA 0
`define PSC_B_CUTB 1
`define PSC_B_STBC 2
`define PSC_B_STBS 3
`define PSC_B_ADC 4
`define PSC_RST_MOD 32'h0000_0000
// flash control
`define PSC_B_FSTOP 0
`define PSC_B_LCRD 1
`define PSC_B_REWR 2
`define PSC_RST_FLASH 32'h0000_0000
// mode: 0 run, 1 wait, 3 stop; bit 2 low-speed osc mode
`define PSC_B_LOWMODE 2
`define PSC_RST_ZERO 32'h0000_0000
// writable bits of each register; the rest read back as zero
`define PSC_MSK_VDET 32'h0000_00E1
`define PSC_MSK_CLK 32'h0000_000F
`define PSC_MSK_MOD 32'h0000_001F
`define PSC_MSK_FLASH 32'h0000_0007
`define PSC_MSK_MODE 32'h0000_0007
`define PSC_MODE_RSVD 2'b10
`endif

// >>> shared/psc_pkg.sv
// types shared by the power-saving control block
package psc_pkg;
  typedef enum logic [1:0] {
    PSC_RUN = 2'b00,
    PSC_WAIT = 2'b01,
    PSC_STOP = 2'b11
  } psc_mode_e;
endpackage

// >>> logic/psc_port_hold.sv
// port direction and output register bank, held through wait and stop
`timescale 1ns/1ps
`include "psc_cfg.svh"
module psc_port_hold #(
  parameter int WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic wr_dir,
  input wire logic wr_out,
  input wire logic lowpower,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] dir_ff,
  output logic [WIDTH-1:0] out_ff
);
  if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
    $error("psc_port_hold: WIDTH out of range");
  end
  // state cannot move while the core sleeps
  wire upd_dir = ce & wr_dir & ~lowpower;
  wire upd_out = ce & wr_out & ~lowpower;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_ff <= '0;
      out_ff <= '0;
    end else begin
      if (upd_dir) dir_ff <= wdata;
      if (upd_out) out_ff <= wdata;
    end
  end
endmodule

// >>> test/psc_sva.sv
// concurrent checks on the power-saving control ports
`timescale 1ns/1ps
module psc_sva #(
  parameter int PORT_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic detect0_on,
  input wire logic detect1_on,
  input wire logic detect2_on,
  input wire logic low_osc_run,
  input wire logic high_osc_run,
  input wire logic timer_a_clk_en,
  input wire logic timer_b_clk_en,
  input wire logic timer_c_standby,
  input wire logic serial_sync_standby,
  input wire logic adc_active,
  input wire logic [PORT_W-1:0] port_dir
);
  logic acc;
  logic wr_vd;
  logic wr_ck;
  logic wr_md;
  logic wr_pd;
  assign acc = psel && penable && pready && clk_en;
  assign wr_vd = acc && pwrite && paddr == 12'h000;
  assign wr_ck = acc && pwrite && paddr == 12'h004;
  assign wr_md = acc && pwrite && paddr == 12'h008;
  assign wr_pd = acc && pwrite && paddr == 12'h018;
  // sleep state mirrored from mode writes, since the mode is not a port
  logic slp_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slp_ff <= 1'b0;
    end else if (acc && pwrite && paddr == 12'h010 && pwdata[1:0] != 2'b10) begin
      slp_ff <= pwdata[1:0] != 2'b00;
    end
  end
  // ========================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_setup: assert property (psel && !penable && clk_en |=> pready)
    else $error("ready missing in access cycle");
  a_ready_pulse: assert property (pready && clk_en |=> !pready)
    else $error("ready held past one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_unmapped_err: assert property (acc && paddr > 12'h01C |-> pslverr)
    else $error("unmapped access not refused");
  a_detect_follow: assert property (wr_vd |=> ##1
    {detect2_on, detect1_on, detect0_on} == $past(pwdata[7:5], 2))
    else $error("detector enables wrong");
  a_osc_follow: assert property (wr_ck |=> ##1
    {low_osc_run, high_osc_run} == {!($past(pwdata[0], 2) && !$past(pwdata[1], 2)),
    $past(pwdata[2], 2)})
    else $error("oscillator run wrong");
  a_module_follow: assert property (wr_md |=> ##1
    {adc_active, serial_sync_standby, timer_c_standby, !timer_b_clk_en, !timer_a_clk_en}
    == $past(pwdata[4:0], 2))
    else $error("module controls wrong");
  a_port_hold: assert property ($changed(port_dir) |-> $past(wr_pd && !slp_ff))
    else $error("port direction changed without write");
  a_freeze_hold: assert property (!clk_en |=> $stable(pready) && $stable(port_dir)
    && $stable({timer_a_clk_en, timer_b_clk_en, adc_active, detect0_on, low_osc_run}))
    else $error("state moved while clock enable low");
endmodule
bind psc_top psc_sva #(.PORT_W(PORT_W)) u_sva (.pclk, .presetn, .clk_en, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .pslverr, .detect0_on, .detect1_on, .detect2_on,
  .low_osc_run, .high_osc_run, .timer_a_clk_en, .timer_b_clk_en, .timer_c_standby,
  .serial_sync_standby, .adc_active, .port_dir);

// >>> test/testbench.sv
// self-checking bench for the power-saving control block
`timescale 1ns/1ps
module testbench;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic detect0_on, detect1_on, detect2_on, low_osc_run, high_osc_run, periph_clk_en;
  logic timer_a_clk_en, timer_b_clk_en, timer_c_standby, serial_sync_standby, adc_active;
  logic flash_power_on, flash_access_block, flash_low_current_read, internal_power_reduced;
  logic [7:0] port_dir, port_out;
  int bad_count, checks_done;
  psc_top #(.PORT_W(8)) dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .detect0_on, .detect1_on, .detect2_on,
    .low_osc_run, .high_osc_run, .periph_clk_en, .timer_a_clk_en, .timer_b_clk_en,
    .timer_c_standby, .serial_sync_standby, .adc_active, .flash_power_on,
    .flash_access_block, .flash_low_current_read, .internal_power_reduced, .port_dir,
    .port_out);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // ========================================
  // apb master: request held until ready seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // outputs move on the write edge itself; wait covers it
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    repeat (3) @(posedge pclk);
  endtask
  // ========================================
  // scenarios
  task automatic t_reset();
    chk({detect2_on, detect1_on, detect0_on, low_osc_run, high_osc_run, periph_clk_en},
      6'h3F);
    chk({timer_a_clk_en, timer_b_clk_en, timer_c_standby, serial_sync_standby, adc_active},
      5'h18);
    chk({flash_power_on, flash_access_block, flash_low_current_read, internal_power_reduced,
      port_dir}, 12'h800);
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk(rd, 32'h0000_00E0);
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk(rd, 32'h0000_0006);
    $display("reset test done");
  endtask
  task automatic t_vdet();
    for (int i = 0; i < 3; i++) begin
      wr(12'h000, 32'h0000_00E0 ^ (32'h0000_0020 << i));
      chk({detect2_on, detect1_on, detect0_on}, 3'h7 ^ (3'h1 << i));
    end
    wr(12'h000, 32'h0000_00E0);
    $display("detector test done");
  endtask
  task automatic t_clk();
    wr(12'h004, 32'h0000_0003);
    chk({low_osc_run, high_osc_run}, 2'h2);
    wr(12'h004, 32'h0000_0005);
    chk({low_osc_run, high_osc_run}, 2'h1);
    wr(12'h004, 32'h0000_0006);
    chk({low_osc_run, high_osc_run}, 2'h3);
    $display("oscillator test done");
  endtask
  task automatic t_mod();
    for (int i = 0; i < 5; i++) begin
      wr(12'h008, 32'h0000_0001 << i);
      chk({adc_active, serial_sync_standby, timer_c_standby, !timer_b_clk_en,
        !timer_a_clk_en}, 32'h0000_0001 << i);
    end
    $display("module test done");
  endtask
  task automatic t_sleep();
    wr(12'h018, 32'h0000_00A5);
    wr(12'h01C, 32'h0000_003C);
    wr(12'h010, 32'h0000_0001);
    chk({periph_clk_en, flash_power_on}, 2'h2);
    wr(12'h004, 32'h0000_000E);
    wr(12'h018, 32'h0000_005A);
    wr(12'h01C, 32'h0000_00C3);
    chk({periph_clk_en, flash_power_on, port_dir}, 10'h0A5);
    chk(port_out, 8'h3C);
    apb(1'b0, 12'h014, 32'h0000_0000);
    chk(rd, 32'h0000_0056);
    wr(12'h00C, 32'h0000_0004);
    wr(12'h010, 32'h0000_0003);
    chk({periph_clk_en, flash_power_on}, 2'h1);
    wr(12'h010, 32'h0000_0000);
    chk({periph_clk_en, flash_power_on}, 2'h3);
    wr(12'h004, 32'h0000_0006);
    $display("sleep test done");
  endtask
  task automatic t_flash();
    wr(12'h00C, 32'h0000_0001); // stop bit from ram code
    chk(flash_access_block, 1'b0);
    wr(12'h010, 32'h0000_0004);
    chk(flash_access_block, 1'b1);
    wr(12'h00C, 32'h0000_0001); // stop bit written first
    wr(12'h00C, 32'h0000_0003); // divide ratio already legal
    chk({flash_access_block, flash_low_current_read}, 2'h3);
    wr(12'h00C, 32'h0000_0000); // cleared before sleep
    wr(12'h000, 32'h0000_00E1); // set just before wait
    wr(12'h010, 32'h0000_0005);
    chk(internal_power_reduced, 1'b1);
    wr(12'h010, 32'h0000_0004);
    wr(12'h000, 32'h0000_00E0); // cleared after wake-up
    chk(internal_power_reduced, 1'b0);
    wr(12'h010, 32'h0000_0000);
    $display("flash test done");
  endtask
  // clock enable low: no answer and no register change until it returns
  task automatic t_freeze();
    wr(12'h008, 32'h0000_0003);
    @(posedge pclk);
    clk_en <= 1'b0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= 1'b1;
    paddr <= 12'h008;
    pwdata <= 32'h0000_0000;
    repeat (4) @(posedge pclk);
    chk({pready, timer_a_clk_en, timer_b_clk_en}, 3'h0);
    clk_en <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({timer_a_clk_en, timer_b_clk_en}, 2'h3);
    $display("freeze test done");
  endtask
  task automatic t_err();
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk({er, rd[30:0]}, 32'h8000_0000);
    apb(1'b1, 12'h0FC, 32'hFFFF_FFFF);
    chk(er, 1'b1);
    $display("error test done");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    {presetn, clk_en, psel, penable, pwrite} = 5'b01000;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_vdet();
    t_clk();
    t_mod();
    t_sleep();
    t_flash();
    t_freeze();
    t_err();
    end_of_test();
  end
  initial begin
    #100000;
    bad_count++;
    end_of_test();
  end
endmodule
